//--- core/gw_panel_pkg.sv
// Package for the gateway front-panel indicator block.
// Holds register offsets, field positions, reset values, timing counts and carriers.
package gw_panel_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS   = 50;
  localparam int BLINK_HALF_NS   = 1_000_000_000;   // 1 s lit, 1 s dark
  localparam int BLINK_HALF_CYC  = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int STRETCH_NS      = 50_000_000;      // 50 ms visible activity pulse
  localparam int STRETCH_CYC     = STRETCH_NS / CLK_PERIOD_NS;
  localparam int CNT_W           = 25;

  // Avalon-MM register map, byte addresses
  localparam int             ADDR_W       = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK  = 4'hc;

  // Control register fields
  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_SVC_BIT  = 1;

  // Interrupt status and mask fields
  localparam int IRQ_W          = 3;
  localparam int IRQ_SVC_BIT    = 0;
  localparam int IRQ_PROG_BIT   = 1;
  localparam int IRQ_BOOT_BIT   = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Button indices
  localparam int BTN_N       = 3;
  localparam int BTN_SVC1    = 0;
  localparam int BTN_SVC2    = 1;
  localparam int BTN_PROG    = 2;

  // Bus condition reported by the KNX protocol stack
  typedef enum logic [1:0] {
    BUS_FAIL       = 2'b00,
    BUS_CONNECTED  = 2'b01,
    BUS_REQUESTING = 2'b10
  } bus_cond_e;

  // Internal gateway state flags seen by the panel
  typedef struct packed {
    logic      startup;          // Device still starting up
    logic      cfg_valid;        // A valid configuration is loaded
    logic      lon_commissioned; // LON interface commissioned
    logic      lon_requesting;   // LON side polling initial values
    bus_cond_e knx_bus;          // KNX bus condition
    logic      knx_transmit_lamp;           // KNX frame being sent
    logic      knx_rx;           // KNX frame being received
  } gw_state_s;

  // Lamp drive group
  typedef struct packed {
    logic service;
    logic prog;
    logic lon_status;
    logic knx_status;
    logic knx_transmit_lamp;
    logic knx_rx;
  } lamps_s;

endpackage

//--- core/btn_sync.sv
// Button input conditioner for panel push buttons.
// Assumes active-low pins from outside the clock domain; a held level and a one-cycle press pulse per button.
`timescale 1ns/1ps
`default_nettype none
module btn_sync #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] pin_n,
  output logic      [N-1:0] pressed,
  output logic      [N-1:0] press_pulse
);

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_btn
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      logic rise_ff;

      // Three-stage capture; the first stage feeds only the second
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_ff <= 1'b1;
          s2_ff <= 1'b1;
          s3_ff <= 1'b1;
        end else begin
          s1_ff <= pin_n[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end

      // A change counts only once the later two stages agree, rejecting single glitches
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          lvl_ff  <= 1'b0;
          rise_ff <= 1'b0;
        end else begin
          rise_ff <= 1'b0;
          if (s2_ff == s3_ff) begin
            lvl_ff  <= ~s3_ff;
            rise_ff <= ~s3_ff & ~lvl_ff;
          end
        end
      end

      assign pressed[gi]     = lvl_ff;
      assign press_pulse[gi] = rise_ff;
    end
  endgenerate

endmodule // btn_sync
`default_nettype wire

//--- core/gw_panel.sv
// Front-panel indicator and button logic for the LON/KNX gateway.
// Assumes gateway state flags on clk, buttons on raw pins, software on Avalon-MM.
//
// Summary of operation
// - Service lamp steadily lit for the whole startup period.
// - After startup, uncommissioned LON: service lamp blinks one second on, one off.
// - Commissioned LON interface keeps the service lamp dark.
// - Programming lamp dark normally, lit only in Lamp_button_a mode.
// - KNX transmit and receive lamps pulse on frame send and receive.
// - Both status lamps lit in startup; alternate blinking without valid configuration.
// - With valid configuration, each status lamp follows its own bus condition.
// - Status lamp lit on bus failure, dark connected, blinking while requesting values.
// - LON status lamp never shows failure; dark unless requesting initial values.
// - Service button press sends a broadcast service-pin message with node identity.
// - Each programming button press toggles Lamp_button_a mode.
// - Programming mode alters only the programming lamp, no protocol behaviour.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gw_panel
  import gw_panel_pkg::*;
#(
  parameter int BLINK_CYCLES   = BLINK_HALF_CYC,
  parameter int STRETCH_CYCLES = STRETCH_CYC
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  // Gateway state and panel pins
  input  wire gw_state_s         gw_state,
  input  wire logic              primary_service_lamp_button_n,
  input  wire logic              secondary_service_lamp_button_n,
  input  wire logic              lamp_button_a_n,
  output lamps_s                 lamps,
  output logic                   service_pin_msg,
  output logic                   knx_prog_mode
);

  localparam logic [CNT_W-1:0] BLINK_LAST   = CNT_W'(BLINK_CYCLES - 1);
  localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH_CYCLES - 1);

  logic [BTN_N-1:0] btn_level;
  logic [BTN_N-1:0] btn_rise;
  logic [CNT_W-1:0] blink_cnt_ff;
  logic             phase_ff;
  logic [CNT_W-1:0] tx_cnt_ff;
  logic [CNT_W-1:0] rx_cnt_ff;
  logic             prog_mode_ff;
  logic             svc_msg_ff;
  logic             startup_d_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic             irq_ff;
  logic             wait_ff;
  logic [31:0]      rdata_ff;
  lamps_s           lamps_ff;
  lamps_s           nxt_lamps;
  logic             wr_take;
  logic             ctrl_wr;
  logic             nxt_prog_mode;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0]      nxt_rdata;

  // Button conditioning for both service buttons and the programming button
  btn_sync #(
    .N (BTN_N)
  ) u_btn_sync (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .pin_n       ({lamp_button_a_n, secondary_service_lamp_button_n,
                   primary_service_lamp_button_n}),
    .pressed     (btn_level),
    .press_pulse (btn_rise)
  );

  // Shared blink timebase; one phase flip per second keeps every blinking lamp in step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink_cnt_ff <= '0;
      phase_ff     <= 1'b1;
    end else if (blink_cnt_ff == BLINK_LAST) begin
      blink_cnt_ff <= '0;
      phase_ff     <= ~phase_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + CNT_W'(1);
    end
  end

  // Activity stretchers: a frame of a few bit times would be invisible on a lamp
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_cnt_ff <= '0;
      rx_cnt_ff <= '0;
    end else begin
      if (gw_state.knx_transmit_lamp) begin
        tx_cnt_ff <= STRETCH_LAST;
      end else if (tx_cnt_ff != '0) begin
        tx_cnt_ff <= tx_cnt_ff - CNT_W'(1);
      end
      if (gw_state.knx_rx) begin
        rx_cnt_ff <= STRETCH_LAST;
      end else if (rx_cnt_ff != '0) begin
        rx_cnt_ff <= rx_cnt_ff - CNT_W'(1);
      end
    end
  end

  // Bus request is taken at the edge where waitrequest is seen low
  assign wr_take = avs_write & ~wait_ff;
  assign ctrl_wr = wr_take & (avs_address == OFS_CTRL) & avs_byteenable[0];

  // Programming mode: a button press toggles it and wins over a same-cycle software write
  always_comb begin
    nxt_prog_mode = prog_mode_ff;
    if (btn_rise[BTN_PROG]) begin
      nxt_prog_mode = ~prog_mode_ff;
    end else if (ctrl_wr) begin
      nxt_prog_mode = avs_writedata[CTRL_PROG_BIT];
    end
  end

  // Mode and service message; the mode is exported only as a flag, and only the programming lamp keys on it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prog_mode_ff <= 1'b0;
      svc_msg_ff   <= 1'b0;
      startup_d_ff <= 1'b1;
    end else begin
      prog_mode_ff <= nxt_prog_mode;
      svc_msg_ff   <= btn_rise[BTN_SVC1] | btn_rise[BTN_SVC2]
                      | (ctrl_wr & avs_writedata[CTRL_SVC_BIT]);
      startup_d_ff <= gw_state.startup;
    end
  end

  // Lamp selection, in priority order startup, configuration, bus condition
  always_comb begin
    nxt_lamps        = '0;
    nxt_lamps.prog   = prog_mode_ff;
    nxt_lamps.knx_transmit_lamp = gw_state.knx_transmit_lamp | (tx_cnt_ff != '0);
    nxt_lamps.knx_rx = gw_state.knx_rx | (rx_cnt_ff != '0);
    if (gw_state.startup) begin
      nxt_lamps.service    = 1'b1;
      nxt_lamps.lon_status = 1'b1;
      nxt_lamps.knx_status = 1'b1;
    end else begin
      nxt_lamps.service = gw_state.lon_commissioned ? 1'b0 : phase_ff;
      if (!gw_state.cfg_valid) begin
        nxt_lamps.lon_status = phase_ff;
        nxt_lamps.knx_status = ~phase_ff;
      end else begin
        // LON failure cannot be seen, so only the request phase lights it
        nxt_lamps.lon_status = gw_state.lon_requesting & phase_ff;
        unique case (gw_state.knx_bus)
          BUS_FAIL:       nxt_lamps.knx_status = 1'b1;
          BUS_CONNECTED:  nxt_lamps.knx_status = 1'b0;
          BUS_REQUESTING: nxt_lamps.knx_status = phase_ff;
          default:        nxt_lamps.knx_status = 1'b1;     // Unknown code shown as failure
        endcase
      end
    end
  end

  // Lamps leave through flip-flops so pins never glitch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lamps_ff <= '0;
    end else begin
      lamps_ff <= nxt_lamps;
    end
  end

  // Interrupt sources: service press, programming press, end of startup
  always_comb begin
    irq_set               = '0;
    irq_set[IRQ_SVC_BIT]  = btn_rise[BTN_SVC1] | btn_rise[BTN_SVC2];
    irq_set[IRQ_PROG_BIT] = btn_rise[BTN_PROG];
    irq_set[IRQ_BOOT_BIT] = startup_d_ff & ~gw_state.startup;
    irq_clr               = '0;
    if (wr_take && avs_address == OFS_IRQ && avs_byteenable[0]) begin
      irq_clr = avs_writedata[IRQ_W-1:0];
    end
  end

  // Sticky status, write one to clear; a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (wr_take && avs_address == OFS_MASK && avs_byteenable[0]) begin
        irq_mask_ff <= avs_writedata[IRQ_W-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read mux; unmapped offsets read as zero and ignore writes
  always_comb begin
    nxt_rdata = '0;
    unique case (avs_address)
      OFS_CTRL: nxt_rdata[CTRL_PROG_BIT] = prog_mode_ff;
      OFS_STAT: nxt_rdata[7:0] = {gw_state.cfg_valid, gw_state.startup, lamps_ff};
      OFS_IRQ:  nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      OFS_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      default:  nxt_rdata = '0;
    endcase
  end

  // One wait state per access: data is captured on the same edge where waitrequest drops for one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else if ((avs_read || avs_write) && wait_ff) begin
      wait_ff  <= 1'b0;
      rdata_ff <= nxt_rdata;
    end else begin
      wait_ff  <= 1'b1;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq             = irq_ff;
  assign lamps           = lamps_ff;
  assign service_pin_msg = svc_msg_ff;
  assign knx_prog_mode   = prog_mode_ff;

  // Checks kept beside the logic they guard

  a_service_boot: assert property (@(posedge clk) disable iff (sys_rst)
    gw_state.startup |=> lamps.service)
    else $error("Service lamp dark during startup");

  a_service_commis: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && gw_state.lon_commissioned) |=> !lamps.service)
    else $error("Service lamp lit after commissioning");

  a_service_blink: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && !gw_state.lon_commissioned) |=> (lamps.service == $past(phase_ff)))
    else $error("Service lamp not following blink phase");

  a_prog_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    btn_rise[BTN_PROG] |=> (prog_mode_ff != $past(prog_mode_ff))
      ##1 (lamps.prog == $past(prog_mode_ff)))
    else $error("Programming press did not toggle mode and lamp");

  a_tx_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    gw_state.knx_transmit_lamp |=> lamps.knx_transmit_lamp ##1 lamps.knx_transmit_lamp)
    else $error("Transmit lamp not pulsed");

  a_alt_blink: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && !gw_state.cfg_valid) |=> (lamps.lon_status != lamps.knx_status))
    else $error("Status lamps not alternating without configuration");

  a_knx_fail: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && gw_state.cfg_valid && gw_state.knx_bus == BUS_FAIL) |=> lamps.knx_status)
    else $error("KNX status lamp dark on bus failure");

  a_lon_no_fail: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && gw_state.cfg_valid && !gw_state.lon_requesting) |=> !lamps.lon_status)
    else $error("LON status lamp lit outside value requests");

  a_svc_message: assert property (@(posedge clk) disable iff (sys_rst)
    (btn_rise[BTN_SVC1] || btn_rise[BTN_SVC2]) |=> service_pin_msg ##1 !service_pin_msg)
    else $error("Service press did not give one message pulse");

  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    (|(irq_stat_ff & irq_mask_ff)) |=> irq)
    else $error("Interrupt not raised for unmasked status");

  a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one wait state");

  a_rx_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    gw_state.knx_rx |=> lamps.knx_rx ##1 lamps.knx_rx)
    else $error("Receive lamp not pulsed");

  a_boot_status: assert property (@(posedge clk) disable iff (sys_rst)
    gw_state.startup |=> (lamps.lon_status && lamps.knx_status))
    else $error("Status lamps dark during startup");

  a_knx_connected: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && gw_state.cfg_valid && gw_state.knx_bus == BUS_CONNECTED)
      |=> !lamps.knx_status)
    else $error("KNX status lamp lit with bus connected");

  a_knx_request: assert property (@(posedge clk) disable iff (sys_rst)
    (!gw_state.startup && gw_state.cfg_valid && gw_state.knx_bus == BUS_REQUESTING)
      |=> (lamps.knx_status == $past(phase_ff)))
    else $error("KNX status lamp not blinking while requesting");

endmodule // gw_panel
`default_nettype wire

//--- tb/gw_panel_far.sv
// Front-panel model: the three push buttons seen from outside the block.
// Assumes the bench calls press() from its main process; pins idle high on pull-ups.
`timescale 1ns/1ps
`default_nettype none
module gw_panel_far
  import gw_panel_pkg::*;
(
  input  wire logic clk,
  output logic      svc1_n,
  output logic      svc2_n,
  output logic      prog_n
);
  logic [BTN_N-1:0] pins_ff;

  // Pull-ups hold every released button high
  initial pins_ff = '1;
  assign svc1_n = pins_ff[BTN_SVC1];
  assign svc2_n = pins_ff[BTN_SVC2];
  assign prog_n = pins_ff[BTN_PROG];

  // Hold long enough to pass the sampling stages, then release as long again
  task automatic press(input int idx);
    @(posedge clk);
    pins_ff[idx] <= 1'b0;
    repeat (10) @(posedge clk);
    pins_ff[idx] <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
endmodule // gw_panel_far
`default_nettype wire

//--- tb/tb_gw_panel.sv
// Self-checking bench for the gateway front-panel block.
// Assumes short blink (8) and stretch (4) counts; buttons come from gw_panel_far.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_gw_panel
  import gw_panel_pkg::*;
;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  gw_state_s         st;
  wire logic         svc1_n;
  wire logic         svc2_n;
  wire logic         prog_n;
  lamps_s            lamps;
  logic              service_pin_msg;
  logic              knx_prog_mode;
  int                failures;
  int                n_tests;
  int                msg_cnt;
  int                cycles;
  int                n;
  int                a;
  logic [31:0]       rd;

  gw_panel #(.BLINK_CYCLES(8), .STRETCH_CYCLES(4)) uut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .gw_state(st), .primary_service_lamp_button_n(svc1_n),
    .secondary_service_lamp_button_n(svc2_n), .lamp_button_a_n(prog_n), .lamps(lamps),
    .service_pin_msg(service_pin_msg), .knx_prog_mode(knx_prog_mode));

  gw_panel_far u_far (.clk(clk), .svc1_n(svc1_n), .svc2_n(svc2_n), .prog_n(prog_n));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts service-pin requests and cuts a hang short
  always @(posedge clk) begin
    if (service_pin_msg === 1'b1) msg_cnt++;
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Request is held until waitrequest is seen low; timeout guards the wait
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= ad;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Lit cycles of lamp b over one blink period, and cycles where status lamps differ
  task automatic count16(input int b);
    n = 0;
    a = 0;
    repeat (16) begin
      @(posedge clk);
      if (lamps[b] === 1'b1) n++;
      if (lamps.lon_status !== lamps.knx_status) a++;
    end
  endtask

  initial begin
    {failures, n_tests, msg_cnt, cycles} = '0;
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    st = '0;
    st.startup = 1'b1;
    cyc(10);
    `CHK(lamps, 6'h00)
    `CHK(avs_waitrequest, 1'b1)
    `CHK(irq, 1'b0)
    sys_rst <= 1'b0;
    cyc(3);
    `CHK(lamps, 6'h2c)
    bus(1'b0, OFS_MASK, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, OFS_IRQ, 32'h0);
    `CHK(rd, 32'h0)
    $display("test reset_startup done");

    st.startup <= 1'b0;
    cyc(2);
    count16(5);
    `CHK(n, 8)
    count16(3);
    `CHK(n, 8)
    `CHK(a, 16)
    $display("test no_config done");

    st.cfg_valid        <= 1'b1;
    st.lon_commissioned <= 1'b1;
    cyc(3);
    `CHK(lamps, 6'h04)
    st.knx_bus <= BUS_CONNECTED;
    cyc(3);
    `CHK(lamps, 6'h00)
    st.knx_bus <= BUS_REQUESTING;
    cyc(2);
    count16(2);
    `CHK(n, 8)
    // The spare bus code must look like a failure, never like a healthy bus
    st.knx_bus <= bus_cond_e'(2'h3);
    cyc(3);
    `CHK(lamps, 6'h04)
    st.knx_bus        <= BUS_CONNECTED;
    st.lon_requesting <= 1'b1;
    cyc(2);
    count16(3);
    `CHK(n, 8)
    st.lon_requesting <= 1'b0;
    $display("test bus_condition done");

    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      st.knx_transmit_lamp <= (i == 0);
      st.knx_rx <= (i == 1);
      @(posedge clk);
      st.knx_transmit_lamp <= 1'b0;
      st.knx_rx <= 1'b0;
      cyc(2);
      `CHK(lamps[1-i], 1'b1)
      cyc(8);
      `CHK(lamps, 6'h00)
    end
    $display("test activity done");

    u_far.press(BTN_SVC1);
    `CHK(msg_cnt, 1)
    u_far.press(BTN_SVC2);
    `CHK(msg_cnt, 2)
    u_far.press(BTN_PROG);
    `CHK(knx_prog_mode, 1'b1)
    `CHK(lamps, 6'h10)
    `CHK(msg_cnt, 2)
    u_far.press(BTN_PROG);
    `CHK(knx_prog_mode, 1'b0)
    `CHK(lamps, 6'h00)
    $display("test buttons done");

    // Sticky events, mask, clear, and an unmapped read
    bus(1'b0, OFS_IRQ, 32'h0);
    `CHK(rd, 32'h7)
    `CHK(irq, 1'b0)
    bus(1'b1, OFS_MASK, 32'h7);
    cyc(2);
    `CHK(irq, 1'b1)
    // A write with lane 0 disabled must leave the mask untouched
    avs_byteenable <= 4'he;
    bus(1'b1, OFS_MASK, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1'b0, OFS_MASK, 32'h0);
    `CHK(rd, 32'h7)
    bus(1'b1, OFS_IRQ, 32'h7);
    cyc(2);
    `CHK(irq, 1'b0)
    bus(1'b0, OFS_STAT, 32'h0);
    `CHK(rd, 32'h80)
    bus(1'b0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, OFS_CTRL, 32'h2);
    cyc(3);
    `CHK(msg_cnt, 3)
    bus(1'b1, OFS_CTRL, 32'h1);
    cyc(3);
    `CHK(lamps, 6'h10)
    $display("test registers done");
    conclude();
  end
endmodule // tb_gw_panel
`default_nettype wire
